// >>> rtl/evt_comb_pkg.sv
// Constants, types and register map of the internal event alarm combiner
package evt_comb_pkg;
   localparam int unsigned NUM_EVENTS       = 5;
   localparam int unsigned ADDR_W           = 8;
   localparam int unsigned DATA_W           = 16;
   localparam int unsigned DLY_W            = 14;
   localparam int unsigned ALARM_W          = 99;
   localparam int unsigned OPTYPE_W         = 6;
   // Time base derived from the system clock
   localparam int unsigned CLK_PERIOD_NS    = 40;
   localparam int unsigned BASE_TICK_NS     = 100_000_000;
   localparam int unsigned BASE_TICK_CYCLES = BASE_TICK_NS / CLK_PERIOD_NS;
   localparam logic [3:0]  TICKS_PER_SEC    = 4'h9;
   localparam logic [5:0]  SECS_PER_MIN     = 6'h3B;
   localparam logic [13:0] DLY_MAX          = 14'h270F;
   // Register map, one 16-bit register per word address
   localparam logic [4:0]  EVT_BLOCKS       = 5'h05;
   localparam logic [2:0]  OFS_CFG3         = 3'h0;
   localparam logic [2:0]  OFS_OPTYPE       = 3'h1;
   localparam logic [2:0]  OFS_THRESH       = 3'h2;
   localparam logic [2:0]  OFS_ON_DLY       = 3'h3;
   localparam logic [2:0]  OFS_OFF_DLY      = 3'h4;
   localparam logic [7:0]  ADDR_IRQ_STAT    = 8'h40;
   localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h41;
   localparam logic [7:0]  ADDR_STATUS      = 8'h42;
   // Reset values
   localparam logic [15:0] CFG3_RST         = 16'h0000;
   localparam logic [5:0]  OPTYPE_RST       = 6'h00;
   localparam logic [15:0] THRESH_RST       = 16'h0000;
   localparam logic [13:0] DLY_RST          = 14'h0000;
   localparam logic [4:0]  MASK_RST         = 5'h00;
   // Digit positions inside the configuration word
   localparam int unsigned DIG_ALARM_LSB    = 0;
   localparam int unsigned DIG_SPECIAL_LSB  = 4;
   localparam int unsigned DIG_UNIT_LSB     = 8;
   localparam logic [3:0]  ALARM_MODE_MAX   = 4'h4;
   localparam logic [3:0]  SPECIAL_ON       = 4'h1;
   localparam logic [3:0]  UNIT_MAX         = 4'h2;
   // Operation type codes
   localparam logic [5:0]  OP_NONE          = 6'h00;
   localparam logic [5:0]  OP_ALARM_STATUS  = 6'h17;

   typedef enum logic [2:0] {
      CMB_NONE    = 3'h0,
      CMB_DIR_OR  = 3'h1,
      CMB_DIR_AND = 3'h2,
      CMB_INV_OR  = 3'h3,
      CMB_INV_AND = 3'h4
   } comb_mode_t;

   typedef enum logic [1:0] {
      UNIT_100MS = 2'h0,
      UNIT_1S    = 2'h1,
      UNIT_1MIN  = 2'h2
   } dly_unit_t;

   typedef enum logic [3:0] {
      DS_OFF      = 4'h1,
      DS_ON_WAIT  = 4'h2,
      DS_ON       = 4'h4,
      DS_OFF_WAIT = 4'h8
   } dly_state_t;

   typedef struct packed {
      comb_mode_t mode;
      logic       special_off;
      dly_unit_t  unit;
   } evt_cfg_t;

   typedef struct packed {
      logic [13:0] on_dly;
      logic [13:0] off_dly;
      dly_unit_t   unit;
   } dly_cfg_t;

   typedef struct packed {
      logic t100ms;
      logic t1s;
      logic t1min;
   } tick_t;
endpackage : evt_comb_pkg

// >>> rtl/evt_delay_unit.sv
// ON/OFF delay timer for one internal event
`timescale 1ns/1ps
module evt_delay_unit (
   input  wire logic                   i_sys_clk,
   input  wire logic                   i_reset_n,
   input  wire logic                   i_level,
   input  wire evt_comb_pkg::dly_cfg_t i_cfg,
   input  wire evt_comb_pkg::tick_t    i_tick,
   output logic                        o_level
);
   evt_comb_pkg::dly_state_t state_r;
   logic [13:0]              cnt_r;
   logic                     unit_tick;

   always_comb begin
      case (i_cfg.unit)
         evt_comb_pkg::UNIT_1S:   unit_tick = i_tick.t1s;
         evt_comb_pkg::UNIT_1MIN: unit_tick = i_tick.t1min;
         default:                 unit_tick = i_tick.t100ms;
      endcase
   end

   // Glitches shorter than the delay are swallowed: a reversal during a wait returns to the old level
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_r <= evt_comb_pkg::DS_OFF;
         cnt_r   <= 14'h0000;
      end else begin
         case (state_r)
            evt_comb_pkg::DS_OFF: begin
               cnt_r <= 14'h0000;
               if (i_level) begin
                  state_r <= (i_cfg.on_dly == 14'h0000) ? evt_comb_pkg::DS_ON : evt_comb_pkg::DS_ON_WAIT;
               end
            end
            evt_comb_pkg::DS_ON_WAIT: begin
               if (!i_level) begin
                  state_r <= evt_comb_pkg::DS_OFF;
               end else if (cnt_r >= i_cfg.on_dly) begin
                  state_r <= evt_comb_pkg::DS_ON;
               end else if (unit_tick) begin
                  cnt_r <= cnt_r + 14'h0001;
               end
            end
            evt_comb_pkg::DS_ON: begin
               cnt_r <= 14'h0000;
               if (!i_level) begin
                  state_r <= (i_cfg.off_dly == 14'h0000) ? evt_comb_pkg::DS_OFF : evt_comb_pkg::DS_OFF_WAIT;
               end
            end
            evt_comb_pkg::DS_OFF_WAIT: begin
               if (i_level) begin
                  state_r <= evt_comb_pkg::DS_ON;
               end else if (cnt_r >= i_cfg.off_dly) begin
                  state_r <= evt_comb_pkg::DS_OFF;
               end else if (unit_tick) begin
                  cnt_r <= cnt_r + 14'h0001;
               end
            end
            default: begin
               state_r <= evt_comb_pkg::DS_OFF;
               cnt_r   <= 14'h0000;
            end
         endcase
      end
   end

   assign o_level = (state_r == evt_comb_pkg::DS_ON) || (state_r == evt_comb_pkg::DS_OFF_WAIT);

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);

   sequence s_on_expire;
      state_r == evt_comb_pkg::DS_ON_WAIT && i_level && cnt_r >= i_cfg.on_dly;
   endsequence

   chk_on_expire: assert property (s_on_expire |=> o_level)
      else $error("ON delay expired but event stayed OFF");
   chk_on_early: assert property (state_r == evt_comb_pkg::DS_ON_WAIT && cnt_r < i_cfg.on_dly |=> !o_level)
      else $error("Event turned ON before its ON delay");
   chk_off_zero: assert property (state_r == evt_comb_pkg::DS_ON && !i_level && i_cfg.off_dly == 14'h0000
                                  |=> !o_level)
      else $error("Zero OFF delay did not turn event OFF");
   chk_unit_min: assert property (i_cfg.unit == evt_comb_pkg::UNIT_1MIN && state_r == evt_comb_pkg::DS_ON_WAIT
                                  && cnt_r < i_cfg.on_dly && !i_tick.t1min && i_level
                                  |=> $stable(cnt_r))
      else $error("Minute-based counter advanced without a minute tick");
endmodule : evt_delay_unit

// >>> rtl/evt_alarm_combiner.sv
// Alarm combining, special OFF and delay stage for five internal events
`timescale 1ns/1ps
module evt_alarm_combiner #(
   parameter int unsigned P_TICK_CYCLES = evt_comb_pkg::BASE_TICK_CYCLES
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_reset_n,
   input  wire logic [4:0]  i_raw_event,
   input  wire logic [98:0] i_numbered_alarm_condition,
   input  wire logic [7:0]  i_addr,
   input  wire logic [15:0] i_wr_data,
   input  wire logic        i_wr_en,
   input  wire logic        i_rd_en,
   output logic      [15:0] o_rd_data,
   output logic      [4:0]  o_event_status,
   output logic             o_alarm_present,
   output logic             o_irq
);
   localparam int unsigned PRE_W = $clog2(P_TICK_CYCLES + 1);
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(P_TICK_CYCLES - 1);

   logic [15:0]            cfg3_r      [5];
   logic [5:0]             optype_r    [5];
   logic [15:0]            thresh_r    [5];
   logic [13:0]            on_dly_r    [5];
   logic [13:0]            off_dly_r   [5];
   evt_comb_pkg::evt_cfg_t cfg         [5];
   logic [4:0]             pre_status;
   logic [4:0]             comb_status;
   logic [4:0]             delayed;
   logic [4:0]             forced_off;
   logic [4:0]             final_status;
   logic [4:0]             event_status_r;
   logic [4:0]             irq_stat_r;
   logic [4:0]             irq_mask_r;
   logic                   irq_r;
   logic                   alarm_present_r;
   logic [15:0]            rd_data_r;
   logic [15:0]            rd_value;
   logic [PRE_W-1:0]       pre_cnt_r;
   logic [3:0]             sec_cnt_r;
   logic [5:0]             min_cnt_r;
   evt_comb_pkg::tick_t    tick_r;
   logic                   evt_hit;
   logic [2:0]             evt_idx;

   assign evt_hit = (i_addr[7:3] < evt_comb_pkg::EVT_BLOCKS);
   assign evt_idx = i_addr[5:3];

   function automatic logic combine(evt_comb_pkg::comb_mode_t mode, logic pre, logic alarm);
      case (mode)
         evt_comb_pkg::CMB_DIR_OR:  combine = pre | alarm;
         evt_comb_pkg::CMB_DIR_AND: combine = pre & alarm;
         evt_comb_pkg::CMB_INV_OR:  combine = pre | ~alarm;
         evt_comb_pkg::CMB_INV_AND: combine = pre & ~alarm;
         default:                   combine = pre;
      endcase
   endfunction : combine

   // One flag for the whole bank of numbered alarms
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         alarm_present_r <= 1'b0;
      end else begin
         alarm_present_r <= |i_numbered_alarm_condition;
      end
   end

   // Time base chain: 0.1 s, then 1 s from ten of those, then 1 min from sixty seconds
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pre_cnt_r <= '0;
         sec_cnt_r <= 4'h0;
         min_cnt_r <= 6'h00;
         tick_r    <= '0;
      end else begin
         tick_r <= '0;
         if (pre_cnt_r == PRE_LAST) begin
            pre_cnt_r     <= '0;
            tick_r.t100ms <= 1'b1;
            if (sec_cnt_r == evt_comb_pkg::TICKS_PER_SEC) begin
               sec_cnt_r  <= 4'h0;
               tick_r.t1s <= 1'b1;
               if (min_cnt_r == evt_comb_pkg::SECS_PER_MIN) begin
                  min_cnt_r    <= 6'h00;
                  tick_r.t1min <= 1'b1;
               end else begin
                  min_cnt_r <= min_cnt_r + 6'h01;
               end
            end else begin
               sec_cnt_r <= sec_cnt_r + 4'h1;
            end
         end else begin
            pre_cnt_r <= pre_cnt_r + PRE_W'(1);
         end
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);

   genvar g;
   generate
      for (g = 0; g < evt_comb_pkg::NUM_EVENTS; g++) begin : g_evt
         logic [3:0]            dig_alarm;
         logic [3:0]            dig_special;
         logic [3:0]            dig_unit;
         logic                  enabled;
         logic                  hold_off;
         evt_comb_pkg::dly_cfg_t dcfg;

         always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               cfg3_r[g]    <= evt_comb_pkg::CFG3_RST;
               optype_r[g]  <= evt_comb_pkg::OPTYPE_RST;
               thresh_r[g]  <= evt_comb_pkg::THRESH_RST;
               on_dly_r[g]  <= evt_comb_pkg::DLY_RST;
               off_dly_r[g] <= evt_comb_pkg::DLY_RST;
            end else if (i_wr_en && evt_hit && evt_idx == 3'(g)) begin
               case (i_addr[2:0])
                  evt_comb_pkg::OFS_CFG3:   cfg3_r[g]   <= i_wr_data;
                  evt_comb_pkg::OFS_OPTYPE: optype_r[g] <= i_wr_data[5:0];
                  evt_comb_pkg::OFS_THRESH: thresh_r[g] <= i_wr_data;
                  evt_comb_pkg::OFS_ON_DLY: begin
                     on_dly_r[g] <= (i_wr_data > {2'h0, evt_comb_pkg::DLY_MAX}) ?
                                    evt_comb_pkg::DLY_MAX : i_wr_data[13:0];
                  end
                  evt_comb_pkg::OFS_OFF_DLY: begin
                     off_dly_r[g] <= (i_wr_data > {2'h0, evt_comb_pkg::DLY_MAX}) ?
                                     evt_comb_pkg::DLY_MAX : i_wr_data[13:0];
                  end
                  default: ;
               endcase
            end
         end

         assign dig_alarm   = cfg3_r[g][evt_comb_pkg::DIG_ALARM_LSB +: 4];
         assign dig_special = cfg3_r[g][evt_comb_pkg::DIG_SPECIAL_LSB +: 4];
         assign dig_unit    = cfg3_r[g][evt_comb_pkg::DIG_UNIT_LSB +: 4];

         // Illegal digits decode as zero so a bad write never yields an undefined mode
         always_comb begin
            cfg[g].mode = (dig_alarm <= evt_comb_pkg::ALARM_MODE_MAX) ?
                          evt_comb_pkg::comb_mode_t'(dig_alarm[2:0]) : evt_comb_pkg::CMB_NONE;
            cfg[g].special_off = (dig_special == evt_comb_pkg::SPECIAL_ON);
            cfg[g].unit = (dig_unit <= evt_comb_pkg::UNIT_MAX) ?
                          evt_comb_pkg::dly_unit_t'(dig_unit[1:0]) : evt_comb_pkg::UNIT_100MS;
         end

         assign enabled  = (optype_r[g] != evt_comb_pkg::OP_NONE);
         assign hold_off = cfg[g].special_off && (thresh_r[g] == 16'h0000);
         assign pre_status[g] = (optype_r[g] == evt_comb_pkg::OP_ALARM_STATUS) ?
                                alarm_present_r : i_raw_event[g];
         assign comb_status[g] = enabled && !hold_off &&
                                 combine(cfg[g].mode, pre_status[g], alarm_present_r);
         // Disable and special OFF bypass the OFF delay, so the event drops at once
         assign forced_off[g] = !enabled || hold_off;
         assign dcfg = '{on_dly: on_dly_r[g], off_dly: off_dly_r[g], unit: cfg[g].unit};

         evt_delay_unit u_delay (
            .i_sys_clk (i_sys_clk),
            .i_reset_n (i_reset_n),
            .i_level   (comb_status[g]),
            .i_cfg     (dcfg),
            .i_tick    (tick_r),
            .o_level   (delayed[g])
         );

         sequence s_or_alarm_held;
            (enabled && !hold_off && cfg[g].mode == evt_comb_pkg::CMB_DIR_OR && alarm_present_r
             && on_dly_r[g] == 14'h0000)[*3];
         endsequence

         chk_mode_none: assert property (enabled && !hold_off && cfg[g].mode == evt_comb_pkg::CMB_NONE
                                         |-> comb_status[g] == pre_status[g])
            else $error("Mode 0 changed the event status");
         chk_dir_or_out: assert property (s_or_alarm_held |=> o_event_status[g])
            else $error("Direct OR with alarm did not turn event ON");
         chk_dir_and: assert property (cfg[g].mode == evt_comb_pkg::CMB_DIR_AND && !alarm_present_r
                                       |-> !comb_status[g])
            else $error("Direct AND turned ON without alarm");
         chk_inv_or: assert property (enabled && !hold_off && cfg[g].mode == evt_comb_pkg::CMB_INV_OR
                                      && !alarm_present_r |-> comb_status[g])
            else $error("Inverted OR stayed OFF without alarm");
         chk_inv_and: assert property (cfg[g].mode == evt_comb_pkg::CMB_INV_AND && alarm_present_r
                                       |-> !comb_status[g])
            else $error("Inverted AND turned ON with alarm");
         chk_special_off: assert property ((dig_special == evt_comb_pkg::SPECIAL_ON
                                            && thresh_r[g] == 16'h0000)[*3] |=> !o_event_status[g])
            else $error("Special OFF did not hold event OFF");
         chk_disabled_off: assert property ((optype_r[g] == evt_comb_pkg::OP_NONE)[*3]
                                            |=> !o_event_status[g])
            else $error("Disabled event reported ON");
         chk_bad_digit: assert property (dig_alarm > evt_comb_pkg::ALARM_MODE_MAX && enabled && !hold_off
                                         |-> comb_status[g] == pre_status[g])
            else $error("Out-of-range alarm digit did not act as mode 0");
         chk_alarm_type: assert property (optype_r[g] == evt_comb_pkg::OP_ALARM_STATUS
                                          |-> pre_status[g] == alarm_present_r)
            else $error("Alarm-status event ignored the alarm flag");
         chk_dir_or_on: assert property (enabled && !hold_off && cfg[g].mode == evt_comb_pkg::CMB_DIR_OR
                                         && alarm_present_r |-> comb_status[g])
            else $error("Direct OR stayed OFF with alarm");
         chk_dir_and_on: assert property (enabled && !hold_off && cfg[g].mode == evt_comb_pkg::CMB_DIR_AND
                                          && pre_status[g] && alarm_present_r |-> comb_status[g])
            else $error("Direct AND stayed OFF with status and alarm");
         chk_inv_or_off: assert property (cfg[g].mode == evt_comb_pkg::CMB_INV_OR && !pre_status[g]
                                          && alarm_present_r |-> !comb_status[g])
            else $error("Inverted OR turned ON with alarm and status OFF");
         chk_inv_and_on: assert property (enabled && !hold_off && cfg[g].mode == evt_comb_pkg::CMB_INV_AND
                                          && pre_status[g] && !alarm_present_r |-> comb_status[g])
            else $error("Inverted AND stayed OFF without alarm");
         chk_forced_off: assert property (forced_off[g] |=> !o_event_status[g])
            else $error("Forced OFF event still reported ON");
         chk_unit_decode: assert property (dig_unit > evt_comb_pkg::UNIT_MAX
                                           |-> cfg[g].unit == evt_comb_pkg::UNIT_100MS)
            else $error("Out-of-range unit digit did not act as the base unit");
         chk_dly_clamp: assert property (on_dly_r[g] <= evt_comb_pkg::DLY_MAX
                                         && off_dly_r[g] <= evt_comb_pkg::DLY_MAX)
            else $error("Delay count above its maximum");
         chk_irq_set: assert property (final_status[g] && !event_status_r[g] |=> irq_stat_r[g])
            else $error("Event turned ON without setting its status bit");
      end
   endgenerate

   chk_alarm_flag: assert property (|i_numbered_alarm_condition |=> o_alarm_present)
      else $error("Alarm flag missed an active alarm condition");
   chk_alarm_clear: assert property (!(|i_numbered_alarm_condition) |=> !o_alarm_present)
      else $error("Alarm flag high with no alarm condition");
   chk_tick_sec: assert property (tick_r.t1s |-> tick_r.t100ms)
      else $error("Second tick without a base tick");
   chk_tick_min: assert property (tick_r.t1min |-> tick_r.t1s)
      else $error("Minute tick without a second tick");

   assign final_status = delayed & ~forced_off;

   // Event outputs and their rising-edge interrupts
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         event_status_r <= 5'h00;
      end else begin
         event_status_r <= final_status;
      end
   end

   // Set beats clear so a turn-ON in the clearing cycle is never lost
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_stat_r <= 5'h00;
      end else begin
         irq_stat_r <= (irq_stat_r & ~((i_wr_en && i_addr == evt_comb_pkg::ADDR_IRQ_STAT) ?
                                       i_wr_data[4:0] : 5'h00)) | (final_status & ~event_status_r);
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_mask_r <= evt_comb_pkg::MASK_RST;
      end else if (i_wr_en && i_addr == evt_comb_pkg::ADDR_IRQ_MASK) begin
         irq_mask_r <= i_wr_data[4:0];
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_stat_r & irq_mask_r);
      end
   end

   chk_irq_level: assert property (|(irq_stat_r & irq_mask_r) |=> o_irq)
      else $error("Interrupt low with an unmasked status bit set");

   // Hidden configuration reads back as zero while the event is disabled
   always_comb begin
      rd_value = 16'h0000;
      if (evt_hit) begin
         case (i_addr[2:0])
            evt_comb_pkg::OFS_CFG3: begin
               rd_value = (optype_r[evt_idx] == evt_comb_pkg::OP_NONE) ? 16'h0000 : cfg3_r[evt_idx];
            end
            evt_comb_pkg::OFS_OPTYPE:  rd_value = {10'h000, optype_r[evt_idx]};
            evt_comb_pkg::OFS_THRESH:  rd_value = thresh_r[evt_idx];
            evt_comb_pkg::OFS_ON_DLY:  rd_value = {2'h0, on_dly_r[evt_idx]};
            evt_comb_pkg::OFS_OFF_DLY: rd_value = {2'h0, off_dly_r[evt_idx]};
            default:                   rd_value = 16'h0000;
         endcase
      end else begin
         case (i_addr)
            evt_comb_pkg::ADDR_IRQ_STAT: rd_value = {11'h000, irq_stat_r};
            evt_comb_pkg::ADDR_IRQ_MASK: rd_value = {11'h000, irq_mask_r};
            evt_comb_pkg::ADDR_STATUS:   rd_value = {10'h000, alarm_present_r, event_status_r};
            default:                     rd_value = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rd_data_r <= 16'h0000;
      end else begin
         rd_data_r <= i_rd_en ? rd_value : 16'h0000;
      end
   end

   chk_cfg_hidden: assert property (i_rd_en && evt_hit && i_addr[2:0] == evt_comb_pkg::OFS_CFG3
                                    && optype_r[evt_idx] == evt_comb_pkg::OP_NONE |=> o_rd_data == 16'h0000)
      else $error("Configuration word visible while event disabled");
   chk_rd_idle: assert property (!i_rd_en |=> o_rd_data == 16'h0000)
      else $error("Read data present without a read strobe");
   chk_irq_quiet: assert property (!(|(irq_stat_r & irq_mask_r)) |=> !o_irq)
      else $error("Interrupt high with no unmasked status bit");

   assign o_rd_data       = rd_data_r;
   assign o_event_status  = event_status_r;
   assign o_alarm_present = alarm_present_r;
   assign o_irq           = irq_r;
endmodule : evt_alarm_combiner

// >>> tb/tb.sv
// Self-checking testbench for the internal event alarm combiner
`timescale 1ns/1ps
module tb;
   localparam int unsigned TICK = 4;
   logic        i_sys_clk;
   logic        i_reset_n;
   logic [4:0]  i_raw_event;
   logic [98:0] i_numbered_alarm_condition;
   logic [7:0]  i_addr;
   logic [15:0] i_wr_data;
   logic        i_wr_en;
   logic        i_rd_en;
   logic [15:0] o_rd_data;
   logic [4:0]  o_event_status;
   logic        o_alarm_present;
   logic        o_irq;
   int          failures;
   int          samples_checked;
   logic [15:0] d;

   evt_alarm_combiner #(.P_TICK_CYCLES(TICK)) dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
      .i_raw_event(i_raw_event), .i_numbered_alarm_condition(i_numbered_alarm_condition),
      .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
      .o_rd_data(o_rd_data), .o_event_status(o_event_status), .o_alarm_present(o_alarm_present),
      .o_irq(o_irq));

   initial begin
      i_sys_clk = 1'b0;
      forever #20 i_sys_clk = ~i_sys_clk;
   end

   task automatic end_sim;
      if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_wr_data <= v;
      i_wr_en <= 1'b1;
      @(posedge i_sys_clk);
      i_wr_en <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd_en <= 1'b1;
      @(posedge i_sys_clk);
      i_rd_en <= 1'b0;
      #1 d = o_rd_data;
   endtask : rd

   task automatic drive(input logic [4:0] r, input logic al);
      @(posedge i_sys_clk);
      i_raw_event <= r;
      i_numbered_alarm_condition <= {al, 97'h0, 1'b0};
      repeat (4) @(posedge i_sys_clk);
      #1;
   endtask : drive

   task automatic t_reset;
      rd(evt_comb_pkg::ADDR_STATUS); chk("status", 16'h0000, d);
      rd(evt_comb_pkg::ADDR_IRQ_MASK); chk("mask", 16'h0000, d);
      rd(8'h22); chk("thresh", 16'h0000, d);
      wr(8'h7F, 16'hFFFF);
      rd(8'h7F); chk("unmapped", 16'h0000, d);
   endtask : t_reset

   task automatic t_modes;
      logic e;
      wr(8'h01, 16'h0001);
      for (int m = 0; m < 6; m++) begin
         wr(8'h00, 16'(m));
         rd(8'h00); chk("cfg word", 16'(m), d);
         for (int k = 0; k < 4; k++) begin
            drive({4'h0, k[0]}, k[1]);
            case (m)
               1: e = k[0] | k[1];
               2: e = k[0] & k[1];
               3: e = k[0] | !k[1];
               4: e = k[0] & !k[1];
               default: e = k[0];
            endcase
            chk("alarm flag", 16'(k[1]), 16'(o_alarm_present));
            chk("combined", 16'(e), 16'(o_event_status[0]));
         end
      end
   endtask : t_modes

   task automatic t_indep;
      for (int g = 1; g < 5; g++) wr(8'(g * 8 + 1), 16'h0001);
      wr(8'h00, 16'h0001);
      drive(5'h0A, 1'b1);
      chk("all events", 16'h000B, 16'(o_event_status));
      rd(evt_comb_pkg::ADDR_STATUS); chk("status word", 16'h002B, d);
   endtask : t_indep

   task automatic t_special;
      wr(8'h00, 16'h0010);
      drive(5'h01, 1'b0);
      chk("special zero", 16'h0000, 16'(o_event_status[0]));
      wr(8'h02, 16'h0005);
      drive(5'h01, 1'b0);
      chk("special set", 16'h0001, 16'(o_event_status[0]));
      wr(8'h02, 16'h0000);
      wr(8'h00, 16'h0020);
      drive(5'h01, 1'b0);
      chk("bad digit", 16'h0001, 16'(o_event_status[0]));
   endtask : t_special

   task automatic t_optype;
      wr(8'h01, 16'h0000);
      drive(5'h01, 1'b0);
      chk("disabled", 16'h0000, 16'(o_event_status[0]));
      rd(8'h00); chk("hidden", 16'h0000, d);
      wr(8'h01, 16'h0017);
      wr(8'h00, 16'h0000);
      drive(5'h00, 1'b1);
      chk("alarm type on", 16'h0001, 16'(o_event_status[0]));
      drive(5'h01, 1'b0);
      chk("alarm type off", 16'h0000, 16'(o_event_status[0]));
      wr(8'h01, 16'h0001);
   endtask : t_optype

   // Tick phase is free-running, so the first count may be short by up to one period of the selected unit
   task automatic t_delay;
      int per;
      int n;
      wr(8'h03, 16'hFFFF);
      rd(8'h03); chk("delay clamp", 16'h270F, d);
      for (int u = 0; u < 3; u++) begin
         per = TICK * ((u == 0) ? 1 : (u == 1) ? 10 : 600);
         wr(8'h03, 16'h0000);
         wr(8'h04, 16'h0000);
         drive(5'h00, 1'b0);
         wr(8'h00, 16'(u << 8));
         wr(8'h03, 16'h0002);
         wr(8'h04, 16'h0002);
         for (int lv = 1; lv >= 0; lv--) begin
            @(posedge i_sys_clk);
            i_raw_event <= 5'(lv);
            n = 0;
            while (o_event_status[0] !== 1'(lv) && n < 2 * per + 4) begin
               @(posedge i_sys_clk);
               #1 n++;
            end
            chk("delay wait", 16'h0001, 16'(n >= per + 4 && o_event_status[0] === 1'(lv)));
            if (n >= 2 * per + 4) end_sim();
         end
      end
      wr(8'h03, 16'h0000);
      wr(8'h04, 16'h0000);
      wr(8'h00, 16'h0000);
   endtask : t_delay

   task automatic t_irq;
      wr(evt_comb_pkg::ADDR_IRQ_STAT, 16'h001F);
      wr(evt_comb_pkg::ADDR_IRQ_MASK, 16'h0001);
      drive(5'h01, 1'b0);
      chk("irq high", 16'h0001, 16'(o_irq));
      rd(evt_comb_pkg::ADDR_IRQ_STAT); chk("irq stat", 16'h0001, d);
      wr(evt_comb_pkg::ADDR_IRQ_STAT, 16'h0001);
      drive(5'h01, 1'b0);
      chk("irq cleared", 16'h0000, 16'(o_irq));
      wr(evt_comb_pkg::ADDR_IRQ_MASK, 16'h0000);
      drive(5'h00, 1'b0);
      drive(5'h01, 1'b0);
      chk("irq masked", 16'h0000, 16'(o_irq));
      rd(evt_comb_pkg::ADDR_IRQ_STAT); chk("stat masked", 16'h0001, d);
   endtask : t_irq

   initial begin
      failures = 0;
      samples_checked = 0;
      i_reset_n = 1'b0;
      i_raw_event = 5'h00;
      i_numbered_alarm_condition = '0;
      i_addr = 8'h00;
      i_wr_data = 16'h0000;
      i_wr_en = 1'b0;
      i_rd_en = 1'b0;
      repeat (4) @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      t_reset();
      t_modes();
      t_special();
      t_optype();
      t_delay();
      t_irq();
      t_indep();
      end_sim();
   end

   initial begin
      #2ms;
      failures++;
      end_sim();
   end
endmodule : tb
